// ===== rtl/irc_capture_top.sv
// ir remote edge capture unit with axi4-lite register slave
// Behaviour
// - each capture is read as low byte and high byte registers
// - value measures time since last capture, or since last overflow when timeout set
// - bit 2 set by captured rising edge, write one clears, zero ignored
// - bit 1 set by captured falling edge, write one clears, zero ignored
// - bit 0 set on counter timeout, write one clears, zero ignored
// - opposite polarity flag stays pending and keeps interrupt up after first serviced
// - repeated same polarity edge overwrites the older capture, no queueing
// - setup bit 6 halts and clears counter; set after reset
// - setup bits 5:4 choose none, rising, falling or both edges; reset 00
// - setup bits 3:2 reject pulses under 2, 8, 16 clocks; reset 00
// - setup bits 1:0 pick counter rate clock/32, /4, /8, /16; reset 00
// - low capture byte read only, reset zero, latest low eight bits
// - high capture byte read only, reset zero, latest high eight bits
module irc_capture_top
  import irc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ADDR_W = AXI_ADDR_W
) (
  input logic aclk,
  input logic aresetn,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [DATA_W-1:0] s_axi_wdata,
  input logic [DATA_W/8-1:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic ir_in,
  output logic irq
);

  // a shorter counter keeps a wrap reachable in simulation; the high byte then reads zero-extended
  if (CNT_W < BYTE_W + 1 || CNT_W > 2 * BYTE_W) begin : g_bad_cnt
    $error("capture counter must be between nine bits and two bytes wide");
  end
  if (ADDR_W != AXI_ADDR_W) begin : g_bad_addr
    $error("address width must match the register map");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ---- registers
  logic [BYTE_W-1:0] flags_reg;
  logic [BYTE_W-1:0] setup_reg;
  logic [BYTE_W-1:0] mask_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] cap_reg;
  logic filt_prev_reg;
  logic irq_reg;

  // ---- bus state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [BYTE_W-1:0] w_byte_reg;
  logic w_lane0_reg;

  // ---- setup fields
  logic halt;
  logic [SEL_W-1:0] edge_sel;
  logic [SEL_W-1:0] filt_sel;
  logic [SEL_W-1:0] rate_sel;

  assign halt = setup_reg[SETUP_HALT];
  assign edge_sel = setup_reg[SETUP_EDGE_LO +: SEL_W];
  assign filt_sel = setup_reg[SETUP_FILT_LO +: SEL_W];
  assign rate_sel = setup_reg[SETUP_RATE_LO +: SEL_W];

  // ---- input path and tick
  logic filt_level;
  logic tick;

  irc_pulse_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ir_in),
    .filt_sel(filt_sel),
    .level(filt_level)
  );

  // divider is held cleared while halted so a restart begins on a full period
  irc_rate_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(halt),
    .rate_sel(rate_sel),
    .tick(tick)
  );

  // ---- edge qualification
  logic rise_evt;
  logic fall_evt;
  logic rise_cap;
  logic fall_cap;
  logic edge_cap;
  logic wrap;
  logic tout_set;

  assign rise_evt = filt_level && !filt_prev_reg;
  assign fall_evt = !filt_level && filt_prev_reg;
  assign rise_cap = rise_evt && edge_sel[EDGE_RISE_BIT];
  assign fall_cap = fall_evt && edge_sel[EDGE_FALL_BIT];
  assign edge_cap = rise_cap || fall_cap;
  assign wrap = count_reg == CNT_MAX;
  assign tout_set = !halt && !edge_cap && tick && wrap;

  // ---- write channel
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;
  logic [IDX_W-1:0] wr_idx;
  logic wr_mapped;
  logic wr_flags;
  logic wr_setup;
  logic wr_mask;

  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign aw_held_next = (aw_held_reg || aw_hs) && !do_write;
  assign w_held_next = (w_held_reg || w_hs) && !do_write;
  assign bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
  assign wr_idx = irc_idx_of(aw_addr_reg);
  assign wr_mapped = irc_idx_mapped(wr_idx);
  assign wr_flags = do_write && w_lane0_reg && (wr_idx == IDX_FLAGS);
  assign wr_setup = do_write && w_lane0_reg && (wr_idx == IDX_SETUP);
  assign wr_mask = do_write && w_lane0_reg && (wr_idx == IDX_MASK);

  // ---- read channel
  logic ar_hs;
  logic rvalid_next;
  logic [IDX_W-1:0] rd_idx;
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] cap_hi;

  assign cap_hi = BYTE_W'(cap_reg >> BYTE_W);
  assign ar_hs = s_axi_arvalid && arready_reg;
  assign rvalid_next = ar_hs || (rvalid_reg && !s_axi_rready);
  assign rd_idx = irc_idx_of(s_axi_araddr);
  assign rd_byte = (rd_idx == IDX_FLAGS) ? (flags_reg & FLAGS_MASK) :
                   (rd_idx == IDX_SETUP) ? (setup_reg & SETUP_MASK) :
                   (rd_idx == IDX_CAP_LO) ? cap_reg[BYTE_W-1:0] :
                   (rd_idx == IDX_CAP_HI) ? cap_hi :
                   (rd_idx == IDX_MASK) ? (mask_reg & FLAGS_MASK) : 8'h00;

  // ---- next register values
  logic [FLAG_N-1:0] flag_clr;
  logic [FLAG_N-1:0] flag_set;
  logic [BYTE_W-1:0] flags_next;
  logic [CNT_W-1:0] count_next;

  // hardware set beats a same-cycle clear so no event is lost
  assign flag_clr = wr_flags ? w_byte_reg[FLAG_N-1:0] : '0;
  assign flag_set = {rise_cap, fall_cap, tout_set};
  assign flags_next = {{(BYTE_W-FLAG_N){1'b0}}, flag_set | (flags_reg[FLAG_N-1:0] & ~flag_clr)};
  assign count_next = halt ? '0 :
                      edge_cap ? '0 :
                      !tick ? count_reg :
                      wrap ? '0 : count_reg + CNT_ONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= FLAGS_RST;
      setup_reg <= SETUP_RST;
      mask_reg <= MASK_RST;
      count_reg <= '0;
      cap_reg <= '0;
      filt_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      if (wr_setup) begin
        setup_reg <= w_byte_reg & SETUP_MASK;
      end
      if (wr_mask) begin
        mask_reg <= w_byte_reg & FLAGS_MASK;
      end
      count_reg <= count_next;
      if (edge_cap) begin
        cap_reg <= count_reg;
      end
      filt_prev_reg <= filt_level;
      irq_reg <= |(flags_reg & mask_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= '0;
      w_lane0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      if (aw_hs) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_byte_reg <= s_axi_wdata[BYTE_W-1:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      awready_reg <= !aw_held_next && !bvalid_next;
      wready_reg <= !w_held_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_hs) begin
        rdata_reg <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
        rresp_reg <= irc_idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq = irq_reg;

  // ---- checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_CAP_BYTES: assert property (edge_cap |=> cap_reg == $past(count_reg) && count_reg == '0)
    else $error("capture did not latch the counter and restart it");

  AST_CAP_HOLD: assert property (!edge_cap |=> cap_reg == $past(cap_reg))
    else $error("capture value changed without a capture edge");

  AST_RISE_FLAG: assert property (rise_cap |=> flags_reg[FLAG_RISE] ##1 flags_reg[FLAG_RISE] || !$past(wr_flags))
    else $error("rising edge flag not set");

  AST_W1C: assert property (wr_flags && w_byte_reg[FLAG_FALL] && !fall_cap |=> !flags_reg[FLAG_FALL])
    else $error("write one did not clear falling edge flag");

  AST_W0_KEEP: assert property (wr_flags && !w_byte_reg[FLAG_TOUT] && flags_reg[FLAG_TOUT] |=> flags_reg[FLAG_TOUT])
    else $error("write zero disturbed the timeout flag");

  AST_TIMEOUT: assert property (!halt && tick && wrap && !edge_cap |=> flags_reg[FLAG_TOUT] && count_reg == '0)
    else $error("counter wrap did not set timeout and restart");

  AST_HALT: assert property (halt |=> count_reg == '0 ##1 (!halt || count_reg == '0))
    else $error("halted counter not held at zero");

  AST_PRESERVE: assert property (flags_reg[FLAG_FALL] && rise_cap && !wr_flags |=> flags_reg[FLAG_FALL] && flags_reg[FLAG_RISE])
    else $error("opposite polarity flag lost");

  AST_IRQ: assert property (1'b1 |=> irq == $past(|(flags_reg & mask_reg)))
    else $error("interrupt does not follow pending unmasked flags");

  AST_NO_EDGE: assert property (edge_sel == 2'h0 |-> !rise_cap && !fall_cap)
    else $error("capture happened with capture disabled");

  AST_RSVD: assert property (ar_hs && rd_idx == IDX_FLAGS |=> s_axi_rdata[DATA_W-1:FLAG_N] == '0)
    else $error("reserved flag bits read nonzero");

  AST_RATE4: assert property (tick && rate_sel == 2'h1 && !halt ##1 rate_sel == 2'h1 && !halt |-> !tick ##1 !tick ##1 !tick)
    else $error("divide by four tick spacing wrong");

endmodule : irc_capture_top

// ===== rtl/irc_pkg.sv
// shared constants, register map and helper functions for the ir edge capture block
package irc_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h01;
  localparam logic [IDX_W-1:0] IDX_SETUP = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CAP_LO = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CAP_HI = 6'h04;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h05;
  localparam int IDX_LSB = 2;

  // capture_event_flags layout
  localparam int FLAG_RISE = 2;
  localparam int FLAG_FALL = 1;
  localparam int FLAG_TOUT = 0;
  localparam int FLAG_N = 3;
  localparam logic [BYTE_W-1:0] FLAGS_MASK = 8'h07;
  localparam logic [BYTE_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [BYTE_W-1:0] MASK_RST = 8'h00;

  // capture_setup layout
  localparam int SETUP_HALT = 6;
  localparam int SETUP_EDGE_LO = 4;
  localparam int SETUP_FILT_LO = 2;
  localparam int SETUP_RATE_LO = 0;
  localparam int SEL_W = 2;
  localparam logic [BYTE_W-1:0] SETUP_MASK = 8'h7f;
  localparam logic [BYTE_W-1:0] SETUP_RST = 8'h40;

  // edge_select bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // count_rate_select divisors
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_SEL0 = 6'h20;
  localparam logic [DIV_W-1:0] DIV_SEL1 = 6'h04;
  localparam logic [DIV_W-1:0] DIV_SEL2 = 6'h08;
  localparam logic [DIV_W-1:0] DIV_SEL3 = 6'h10;

  // pulse_filter_select lengths in system clocks, zero means bypass
  localparam int FILT_W = 5;
  localparam logic [FILT_W-1:0] FILT_SEL0 = 5'h00;
  localparam logic [FILT_W-1:0] FILT_SEL1 = 5'h02;
  localparam logic [FILT_W-1:0] FILT_SEL2 = 5'h08;
  localparam logic [FILT_W-1:0] FILT_SEL3 = 5'h10;

  function automatic logic [DIV_W-1:0] irc_rate_div_of(input logic [SEL_W-1:0] sel);
    case (sel)
      2'h1: irc_rate_div_of = DIV_SEL1;
      2'h2: irc_rate_div_of = DIV_SEL2;
      2'h3: irc_rate_div_of = DIV_SEL3;
      default: irc_rate_div_of = DIV_SEL0;
    endcase
  endfunction : irc_rate_div_of

  function automatic logic [FILT_W-1:0] irc_filt_len_of(input logic [SEL_W-1:0] sel);
    case (sel)
      2'h1: irc_filt_len_of = FILT_SEL1;
      2'h2: irc_filt_len_of = FILT_SEL2;
      2'h3: irc_filt_len_of = FILT_SEL3;
      default: irc_filt_len_of = FILT_SEL0;
    endcase
  endfunction : irc_filt_len_of

  function automatic logic [IDX_W-1:0] irc_idx_of(input logic [AXI_ADDR_W-1:0] addr);
    irc_idx_of = addr[IDX_LSB +: IDX_W];
  endfunction : irc_idx_of

  function automatic logic irc_idx_mapped(input logic [IDX_W-1:0] idx);
    irc_idx_mapped = (idx >= IDX_FLAGS) && (idx <= IDX_MASK);
  endfunction : irc_idx_mapped

endpackage : irc_pkg

// ===== rtl/irc_pulse_filter.sv
// pin synchroniser and glitch filter for the demodulated ir input
module irc_pulse_filter
  import irc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic pin_in,
  input logic [SEL_W-1:0] filt_sel,
  output logic level
);

  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic [FILT_W-1:0] run_reg;
  logic [FILT_W-1:0] filt_len;
  logic differs;
  logic accept;

  assign filt_len = irc_filt_len_of(filt_sel);
  assign differs = sync2_reg != level_reg;
  // a new level is taken only once it has stood filt_len clocks
  assign accept = (filt_len == FILT_SEL0) || (run_reg >= filt_len - 5'h01);
  assign level = level_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      level_reg <= 1'b0;
      run_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      if (differs && accept) begin
        level_reg <= sync2_reg;
        run_reg <= '0;
      end else begin
        run_reg <= differs ? run_reg + 5'h01 : '0;
      end
    end
  end

endmodule : irc_pulse_filter

// ===== rtl/irc_rate_div.sv
// divider that turns the system clock into the capture counter tick
module irc_rate_div
  import irc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic clear,
  input logic [SEL_W-1:0] rate_sel,
  output logic tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic tick_reg;
  logic [DIV_W-1:0] div_last;
  logic at_last;

  assign div_last = irc_rate_div_of(rate_sel) - 6'h01;
  // >= so a rate change to a shorter divisor cannot overrun the count
  assign at_last = cnt_reg >= div_last;
  assign tick = tick_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= at_last ? '0 : cnt_reg + 6'h01;
      tick_reg <= at_last;
    end
  end

endmodule : irc_rate_div

// ===== test/irc_ir_source.sv
// behavioural model of the ir receiver output feeding the capture unit
module irc_ir_source (
  input wire logic aclk,
  output logic ir_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // receiver output idles high; a burst shows as a low pulse
  initial begin
    ir_out = 1'b1;
  end

  // level changes just after an edge and is held for whole system clocks
  task automatic hold(input logic lvl, input int cycles);
    ir_out <= lvl;
    repeat (cycles) @(posedge aclk);
  endtask : hold

  task automatic pulse_low(input int low_cycles, input int high_cycles);
    hold(1'b0, low_cycles);
    hold(1'b1, high_cycles);
  endtask : pulse_low
endmodule : irc_ir_source

// ===== test/tb.sv
// self-checking bench for the ir edge capture unit over axi4-lite
module tb
  import irc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // shortened counter so that a wrap fits in the run
  localparam int CNT_W_TB = 10;
  localparam logic [AXI_ADDR_W-1:0] A_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] A_SETUP = {IDX_SETUP, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] A_LO = {IDX_CAP_LO, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] A_HI = {IDX_CAP_HI, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] A_MASK = {IDX_MASK, 2'b00};

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = '0;
  logic [AXI_ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, ir_line;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic [15:0] cap;
  int num_errors = 0;
  int n_compared = 0;
  int div_tbl[4] = '{32, 4, 8, 16};
  int flen[4] = '{0, 2, 8, 16};

  always #20 aclk = ~aclk;

  irc_capture_top #(.CNT_W(CNT_W_TB), .ADDR_W(AXI_ADDR_W)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ir_in(ir_line), .irq(irq)
  );

  irc_ir_source src (.aclk(aclk), .ir_out(ir_line));

  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // counter tick phase is free, so intervals are judged within a tolerance
  task automatic chk_near(input string name, input logic [31:0] seen, input logic [31:0] exp, input int tol);
    if (seen >= exp - tol && seen <= exp + tol) begin
      check(name, seen, seen);
    end else begin
      check(name, seen, exp);
    end
  endtask : chk_near

  task automatic axi_write(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] v, output logic [1:0] rr);
    int t;
    logic aw_pend, w_pend, done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    done = 1'b0;
    rr = 2'h3;
    t = 0;
    while (!done && t < 100) begin
      @(posedge aclk);
      t++;
      if (aw_pend && awready === 1'b1) begin
        aw_pend = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_pend && wready === 1'b1) begin
        w_pend = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        done = 1'b1;
        rr = bresp;
        bready <= 1'b0;
      end
    end
    if (!done) begin
      num_errors++;
      report_and_stop();
    end
  endtask : axi_write

  task automatic axi_read(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rr);
    int t;
    logic ar_pend, done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_pend = 1'b1;
    done = 1'b0;
    v = '0;
    rr = 2'h3;
    t = 0;
    while (!done && t < 100) begin
      @(posedge aclk);
      t++;
      if (ar_pend && arready === 1'b1) begin
        ar_pend = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        done = 1'b1;
        v = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end
    if (!done) begin
      num_errors++;
      report_and_stop();
    end
  endtask : axi_read

  task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] v);
    logic [1:0] rr;
    axi_write(a, v, rr);
  endtask : wr

  task automatic rd_chk(input string name, input logic [AXI_ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rr;
    axi_read(a, v, rr);
    check(name, v, exp);
  endtask : rd_chk

  task automatic rd_cap(output logic [15:0] v);
    logic [31:0] lo, hi;
    logic [1:0] rr;
    axi_read(A_LO, lo, rr);
    axi_read(A_HI, hi, rr);
    v = {hi[7:0], lo[7:0]};
  endtask : rd_cap

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("flags", A_FLAGS, 32'h0);
    rd_chk("setup", A_SETUP, 32'h40);
    rd_chk("cap_lo", A_LO, 32'h0);
    rd_chk("cap_hi", A_HI, 32'h0);
    rd_chk("mask", A_MASK, 32'h0);
    axi_read(8'h00, d, r);
    check("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(8'h18, 8'h01, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(A_SETUP, 8'hff);
    rd_chk("setup", A_SETUP, 32'h7f);
    wr(A_FLAGS, 8'hf8);
    rd_chk("flags", A_FLAGS, 32'h0);
    wr(A_LO, 8'h5a);
    rd_chk("cap_lo", A_LO, 32'h0);
    wr(A_MASK, 8'h07);
    // every edge selection, one low pulse each
    for (int e = 0; e < 4; e++) begin
      wr(A_SETUP, {2'b00, e[1:0], 4'h1});
      wr(A_FLAGS, 8'h07);
      src.pulse_low(40, 30);
      rd_chk("flags", A_FLAGS, {29'h0, e[0], e[1], 1'b0});
      check("irq", {31'h0, irq}, {31'h0, e != 0});
    end
    rd_cap(cap);
    chk_near("capture", {16'h0, cap}, 32'd10, 1);
    wr(A_MASK, 8'h01);
    // interrupt output lags the mask by one clock
    @(posedge aclk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(A_MASK, 8'h07);
    wr(A_FLAGS, 8'h04);
    rd_chk("flags", A_FLAGS, 32'h2);
    check("irq", {31'h0, irq}, 32'h1);
    wr(A_FLAGS, 8'h00);
    rd_chk("flags", A_FLAGS, 32'h2);
    wr(A_FLAGS, 8'h02);
    rd_chk("flags", A_FLAGS, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    // two rising edges before service: the newer interval replaces the older
    wr(A_SETUP, 8'h11);
    wr(A_FLAGS, 8'h07);
    src.pulse_low(50, 100);
    src.pulse_low(200, 30);
    rd_cap(cap);
    chk_near("capture", {16'h0, cap}, 32'd75, 1);
    rd_chk("flags", A_FLAGS, 32'h4);
    // every counter rate over one fixed interval; /4 reaches the high byte
    for (int s = 0; s < 4; s++) begin
      wr(A_SETUP, {6'h0c, s[1:0]});
      src.pulse_low(1920, 30);
      rd_cap(cap);
      chk_near("capture", {16'h0, cap}, 1920 / div_tbl[s], 1);
    end
    // glitch just under the filter length is dropped, a longer one passes
    for (int s = 1; s < 4; s++) begin
      wr(A_SETUP, {4'h3, s[1:0], 2'b01});
      wr(A_FLAGS, 8'h07);
      src.pulse_low(flen[s] - 1, 40);
      rd_chk("flags", A_FLAGS, 32'h0);
      src.pulse_low(flen[s] + 2, 40);
      rd_chk("flags", A_FLAGS, 32'h6);
    end
    // counter wraps with no edge; next capture measures from the wrap
    wr(A_SETUP, 8'h31);
    wr(A_FLAGS, 8'h07);
    src.hold(1'b0, 20);
    src.hold(1'b1, (1 << CNT_W_TB) * 4 + 400);
    src.hold(1'b0, 30);
    rd_cap(cap);
    chk_near("capture", {16'h0, cap}, 32'd100, 2);
    rd_chk("flags", A_FLAGS, 32'h7);
    src.hold(1'b1, 30);
    wr(A_FLAGS, 8'h01);
    rd_chk("flags", A_FLAGS, 32'h6);
    // halted counter stays at zero
    wr(A_SETUP, 8'h71);
    src.pulse_low(200, 30);
    rd_cap(cap);
    check("capture", {16'h0, cap}, 32'h0);
    report_and_stop();
  end

  // whole sequence needs about 14000 clocks
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end
endmodule : tb
